// ---- src/qcm_regs.vh ----
// Register map, field positions and reset values of the quadrature counter block.
// Assumes a 32-bit APB slave with word-aligned registers; no logic lives here.
`ifndef QCM_REGS_VH
`define QCM_REGS_VH
`define QCM_ADDR_CONTROL 12'h000
`define QCM_ADDR_TIMER_HIGH 12'h004
`define QCM_ADDR_TIMER_LOW 12'h008
`define QCM_ADDR_POS_HIGH 12'h00c
`define QCM_ADDR_POS_LOW 12'h010
`define QCM_ADDR_INDEX_CFG 12'h014
`define QCM_ADDR_VELOCITY 12'h018
`define QCM_ADDR_INDEX_COUNT 12'h01c
`define QCM_CTL_ENABLE 15
`define QCM_CTL_PRESCALE_HI 6
`define QCM_CTL_PRESCALE_LO 4
`define QCM_CTL_DIR_SELECT 3
`define QCM_CTL_GATE_ENABLE 2
`define QCM_CTL_MODE_HI 1
`define QCM_CTL_MODE_LO 0
`define QCM_CTL_RESET 16'h0000
`define QCM_CTL_WMASK 16'h807f
`define QCM_IDX_MATCH_A 0
`define QCM_IDX_MATCH_B 1
`define QCM_IDX_SWAP 2
`define QCM_IDX_POL_A 3
`define QCM_IDX_POL_B 4
`define QCM_IDX_MATCH_EN 5
`define QCM_IDX_INIT_HI 10
`define QCM_IDX_INIT_LO 8
`define QCM_IDX_RESET 16'h0000
`define QCM_IDX_WMASK 16'h073f
`define QCM_TIMER_RESET 32'h0000_0000
`define QCM_MODE_QUAD 2'h0
`define QCM_MODE_EXT_DIR 2'h1
`define QCM_MODE_EXT_CLK 2'h2
`define QCM_MODE_TIMER 2'h3
`endif

// ---- src/qcm_prescaler.v ----
// Counter clock prescaler: one-cycle tick at clock divided by 2**code.
// Assumes a single clock domain; code may change at any time.
`timescale 1ns/1ns
module qcm_prescaler #(
  parameter WIDTH = 7
) (
  input wire clock,
  input wire resetn,
  input wire enable,
  input wire [2:0] code,
  output reg tick
);
  reg [WIDTH-1:0] divCount_q;
  wire [WIDTH-1:0] divMask;

  // Mask of low bits that must all be one; code 0 gives a tick every cycle.
  assign divMask = ~({WIDTH{1'b1}} << code);

  // The divider free-runs so that a code change takes effect within one period.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      divCount_q <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (!enable) begin
      divCount_q <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else begin
      divCount_q <= divCount_q + {{(WIDTH-1){1'b0}}, 1'b1};
      tick <= ((divCount_q & divMask) == divMask);
    end
  end
endmodule // qcm_prescaler

// ---- src/qcm_phase_decode.v ----
// Synchronises and conditions the encoder phases, then decodes count events.
// Assumes phase, clock, direction and gate pins are asynchronous to clock.
`timescale 1ns/1ns
module qcm_phase_decode (
  input wire clock,
  input wire resetn,
  input wire phaseAPin,
  input wire phaseBPin,
  input wire upDownPin,
  input wire gatePin,
  input wire swap,
  input wire polA,
  input wire polB,
  output reg phaseA,
  output reg phaseB,
  output reg upDown,
  output reg gate,
  output reg quadStep,
  output reg quadUp,
  output reg extEdge
);
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  wire condA;
  wire condB;

  // Swap first, then per-phase inversion, as the index compare expects.
  assign condA = (swap ? sync2_q[1] : sync2_q[0]) ^ polA;
  assign condB = (swap ? sync2_q[0] : sync2_q[1]) ^ polB;

  // Two-stage synchronisers; only the second stage feeds any logic.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      phaseA <= 1'b0;
      phaseB <= 1'b0;
      upDown <= 1'b0;
      gate <= 1'b0;
      quadStep <= 1'b0;
      quadUp <= 1'b0;
      extEdge <= 1'b0;
    end else begin
      sync1_q <= {gatePin, upDownPin, phaseBPin, phaseAPin};
      sync2_q <= sync1_q;
      phaseA <= condA;
      phaseB <= condB;
      upDown <= sync2_q[2];
      gate <= sync2_q[3];
      // Every edge of either phase is a step; direction from A xor previous B.
      quadStep <= (condA ^ phaseA) | (condB ^ phaseB);
      quadUp <= condA ^ phaseB;
      // Rising edge of phase A serves as the external count clock.
      extEdge <= condA & ~phaseA;
    end
  end
endmodule // qcm_phase_decode

// ---- src/qcm_counter.v ----
// Quadrature counter and mode control: position, velocity, index and interval
// counters behind a 32-bit APB slave. Assumes APB master on the same clock and
// encoder pins asynchronous to it.
// Register map, byte offsets, one 32-bit word each.
// 0x000 control: bit 15 enable, bits 6:4 prescale code, bit 3 direction select,
//       bit 2 gate enable, bits 1:0 counter mode.
// 0x004 interval timer upper half; 0x008 interval timer lower half.
// 0x00c position upper half; 0x010 position lower half.
// 0x014 index setup: bits 1:0 match value, bit 2 swap, bits 4:3 polarity,
//       bit 5 match enable, bits 10:8 position init mode.
// 0x018 velocity, read only; 0x01c index count, read only.
// Counter modes: 00 quadrature x4, 01 external clock with direction pin,
// 10 external clock, 11 internal timer.
//
// Hazards and limits.
// Pin events reach the counters about four cycles after the pin moves, behind two
// synchroniser stages and one stage that conditions and decodes at once.
// A step pulse lasts one cycle and is only taken on a tick, so a slow prescale
// loses encoder edges; software must keep the tick rate high enough.
// Word writes to the timer or position change only their half, so a carry between
// the two writes can leave a torn value; stop the block before loading both halves.
// The index clear needs no tick and wins over counting; a word write wins over both.
// Reading one half of a running counter takes no snapshot of the other half.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "qcm_regs.vh"
module qcm_counter #(
  parameter PRESCALE_WIDTH = 7
) (
  input wire clock,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire phaseAInput,
  input wire phaseBInput,
  input wire upDownInput,
  input wire gateInput,
  output reg [31:0] positionCount,
  output reg countDirUp
);
  reg [15:0] control_q;
  reg [15:0] indexCfg_q;
  reg [31:0] timer_q;
  reg [31:0] velocity_q;
  reg [31:0] indexCount_q;
  reg [31:0] timer_d;
  reg [31:0] position_d;
  reg step;
  reg stepUp;
  wire tick;
  wire phaseA;
  wire phaseB;
  wire upDownSync;
  wire gateSync;
  wire quadStep;
  wire quadUp;
  wire extEdge;
  wire enabled;
  wire [2:0] prescale;
  wire [1:0] mode;
  wire timerModes;
  wire gateOpen;
  wire indexMatch;
  wire wrEn;
  wire rdEn;
  wire mapped;
  wire [2:0] initMode;

  // One step up or down; the position, velocity and index counters all share it.
  function [31:0] stepValue;
    input [31:0] value;
    input up;
    begin
      stepValue = up ? value + 32'h0000_0001 : value - 32'h0000_0001;
    end
  endfunction

  // A word is mapped at every aligned offset up to the index count; the rest is refused.
  function addrMapped;
    input [11:0] addr;
    begin
      addrMapped = (addr[1:0] == 2'h0) && (addr <= `QCM_ADDR_INDEX_COUNT);
    end
  endfunction

  // Field extraction from the control register.
  assign enabled = control_q[`QCM_CTL_ENABLE];
  assign prescale = control_q[`QCM_CTL_PRESCALE_HI:`QCM_CTL_PRESCALE_LO];
  assign mode = control_q[`QCM_CTL_MODE_HI:`QCM_CTL_MODE_LO];
  assign timerModes = (mode == `QCM_MODE_EXT_CLK) || (mode == `QCM_MODE_TIMER);
  // The init mode field only matters outside the timer modes.
  assign initMode = timerModes ? 3'h0 : indexCfg_q[`QCM_IDX_INIT_HI:`QCM_IDX_INIT_LO];
  // A closed gate only stops counting when gating is enabled.
  assign gateOpen = ~control_q[`QCM_CTL_GATE_ENABLE] | gateSync;

  // Index match on conditioned phases; only meaningful in quadrature mode.
  assign indexMatch = (mode == `QCM_MODE_QUAD) && indexCfg_q[`QCM_IDX_MATCH_EN] &&
                      (phaseA == indexCfg_q[`QCM_IDX_MATCH_A]) &&
                      (phaseB == indexCfg_q[`QCM_IDX_MATCH_B]);

  qcm_prescaler #(
    .WIDTH(PRESCALE_WIDTH)
  ) prescaler (
    .clock(clock),
    .resetn(resetn),
    .enable(enabled),
    .code(prescale),
    .tick(tick)
  );

  qcm_phase_decode decode (
    .clock(clock),
    .resetn(resetn),
    .phaseAPin(phaseAInput),
    .phaseBPin(phaseBInput),
    .upDownPin(upDownInput),
    .gatePin(gateInput),
    .swap(indexCfg_q[`QCM_IDX_SWAP]),
    .polA(indexCfg_q[`QCM_IDX_POL_A]),
    .polB(indexCfg_q[`QCM_IDX_POL_B]),
    .phaseA(phaseA),
    .phaseB(phaseB),
    .upDown(upDownSync),
    .gate(gateSync),
    .quadStep(quadStep),
    .quadUp(quadUp),
    .extEdge(extEdge)
  );

  // Count step selection per mode. Pin events are only accepted on a tick, so
  // a step that falls between two ticks is lost; software must
  // keep the prescaled rate high enough.
  always @* begin
    step = 1'b0;
    stepUp = 1'b1;
    case (mode)
      `QCM_MODE_QUAD: begin
        step = quadStep;
        stepUp = quadUp;
      end
      `QCM_MODE_EXT_DIR: begin
        step = extEdge;
        stepUp = upDownSync;
      end
      `QCM_MODE_EXT_CLK: begin
        step = extEdge;
        stepUp = ~control_q[`QCM_CTL_DIR_SELECT] | upDownSync;
      end
      default: begin
        step = 1'b1;
        stepUp = ~control_q[`QCM_CTL_DIR_SELECT] | upDownSync;
      end
    endcase
  end

  // Next position value: index clear has priority over counting.
  always @* begin
    position_d = positionCount;
    if (enabled && indexMatch) begin
      position_d = 32'h0000_0000;
    end else if (enabled && tick && step && gateOpen) begin
      position_d = stepValue(positionCount, stepUp);
    end
  end

  // Interval timer next value, with software word writes taking priority.
  always @* begin
    timer_d = timer_q;
    if (enabled && tick) begin
      timer_d = timer_q + 32'h0000_0001;
    end
    if (wrEn && paddr == `QCM_ADDR_TIMER_HIGH) begin
      timer_d = {pwdata[15:0], timer_q[15:0]};
    end else if (wrEn && paddr == `QCM_ADDR_TIMER_LOW) begin
      timer_d = {timer_q[31:16], pwdata[15:0]};
    end
  end

  // Counter state.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_q <= `QCM_TIMER_RESET;
      positionCount <= `QCM_TIMER_RESET;
      velocity_q <= `QCM_TIMER_RESET;
      indexCount_q <= `QCM_TIMER_RESET;
      countDirUp <= 1'b1;
    end else begin
      timer_q <= timer_d;
      if (wrEn && paddr == `QCM_ADDR_POS_HIGH) begin
        positionCount <= {pwdata[15:0], positionCount[15:0]};
      end else if (wrEn && paddr == `QCM_ADDR_POS_LOW) begin
        positionCount <= {positionCount[31:16], pwdata[15:0]};
      end else begin
        positionCount <= position_d;
      end
      if (enabled && tick && step && gateOpen) begin
        countDirUp <= stepUp;
        velocity_q <= stepValue(velocity_q, stepUp);
      end
      // Index counter counts matches in quadrature mode with init mode 000, ticks as a timer in modes 10 and 11, and holds in mode 01.
      if (enabled && tick && (timerModes || (indexMatch && initMode == 3'h0))) begin
        indexCount_q <= stepValue(indexCount_q, timerModes || stepUp);
      end
    end
  end

  // APB decode: zero-wait answer in the access phase, error on unmapped address.
  assign wrEn = psel && penable && pwrite && mapped;
  assign rdEn = psel && !penable && !pwrite;
  assign mapped = addrMapped(paddr);

  // Control and index configuration writes; reserved bits stay zero.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control_q <= `QCM_CTL_RESET;
      indexCfg_q <= `QCM_IDX_RESET;
    end else begin
      if (wrEn && paddr == `QCM_ADDR_CONTROL) begin
        control_q <= pwdata[15:0] & `QCM_CTL_WMASK;
      end
      if (wrEn && paddr == `QCM_ADDR_INDEX_CFG) begin
        indexCfg_q <= pwdata[15:0] & `QCM_IDX_WMASK;
      end
    end
  end

  // Read data is latched in the setup phase so every output comes from a flop.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrMapped(paddr);
      if (rdEn) begin
        if (paddr == `QCM_ADDR_CONTROL) begin
          prdata <= {16'h0000, control_q};
        end else if (paddr == `QCM_ADDR_TIMER_HIGH) begin
          prdata <= {16'h0000, timer_q[31:16]};
        end else if (paddr == `QCM_ADDR_TIMER_LOW) begin
          prdata <= {16'h0000, timer_q[15:0]};
        end else if (paddr == `QCM_ADDR_POS_HIGH) begin
          prdata <= {16'h0000, positionCount[31:16]};
        end else if (paddr == `QCM_ADDR_POS_LOW) begin
          prdata <= {16'h0000, positionCount[15:0]};
        end else if (paddr == `QCM_ADDR_INDEX_CFG) begin
          prdata <= {16'h0000, indexCfg_q};
        end else if (paddr == `QCM_ADDR_VELOCITY) begin
          prdata <= velocity_q;
        end else if (paddr == `QCM_ADDR_INDEX_COUNT) begin
          prdata <= indexCount_q;
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end
endmodule // qcm_counter

// ---- test/qcm_encoder_model.sv ----
// Behavioural incremental encoder driving the two phase pins.
// Assumes the bench pulses stepReq for one cycle per step.
`timescale 1ns/1ns
module qcm_encoder_model (
  input wire clock,
  input wire resetn,
  input wire stepReq,
  input wire stepUp,
  input wire quad,
  output logic phaseA,
  output logic phaseB
);
  logic [1:0] state_q;
  // Gray sequence with phase A leading for up; otherwise A alone toggles as a clock.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= 2'h0;
    end else if (stepReq) begin
      state_q <= quad ? (stepUp ? state_q + 2'h1 : state_q - 2'h1) : state_q ^ 2'h1;
    end
  end
  // Only one phase changes per step, which the x4 decoder relies on.
  assign phaseA = state_q[0] ^ state_q[1];
  assign phaseB = state_q[1];
endmodule // qcm_encoder_model

// ---- test/qcm_counter_chk.sv ----
// Checker of the quadrature counter block, bound to its top module.
// Assumes the APB slave answers in the first access cycle, with no wait state.
`timescale 1ns/1ns
module qcm_counter_chk #(
  parameter PRESCALE_WIDTH = 7
) (
  input logic clock,
  input logic resetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [31:0] positionCount,
  input logic countDirUp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad_addr;
    paddr > 12'h01c || paddr[1:0] != 2'h0;
  endsequence
  sequence s_good_addr;
    paddr <= 12'h01c && paddr[1:0] == 2'h0;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_refused: assert property (s_setup ##0 s_bad_addr |=> pslverr)
    else $error("bad address not refused");
  a_ok_mapped: assert property (s_setup ##0 s_good_addr |=> !pslverr)
    else $error("mapped address refused");
  a_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_data_held: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without read");
  a_step_by_one: assert property (!$past(psel && penable && pwrite)
    && positionCount != $past(positionCount) |-> positionCount == $past(positionCount) + 32'h1
    || positionCount == $past(positionCount) - 32'h1 || positionCount == 32'h0)
    else $error("position jumped");
  a_dir_follows: assert property (!$past(psel && penable && pwrite)
    && positionCount == $past(positionCount) + 32'h1 |-> countDirUp)
    else $error("direction flag wrong");
endmodule // qcm_counter_chk

// ---- test/testbench.sv ----
// Self-checking bench of the quadrature counter block.
// Assumes zero-wait APB, up/down pin high meaning up, enable in control bit 15.
`timescale 1ns/1ns
module testbench;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, positionCount, r, p0;
  logic pready, pslverr, countDirUp, lastErr, phA, phB, gateBit;
  logic upDownInput = 0, gateInput = 0, stepReq = 0, stepUp = 1, quad = 1;
  int miscompares = 0, compares = 0, k, n, opened;
  // The clock toggles every half period of 25 ns.
  always #25 clock = ~clock;
  qcm_counter #(.PRESCALE_WIDTH(7)) u_dut (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phaseAInput(phA), .phaseBInput(phB),
    .upDownInput(upDownInput), .gateInput(gateInput), .positionCount(positionCount),
    .countDirUp(countDirUp));
  qcm_encoder_model u_enc (.clock(clock), .resetn(resetn), .stepReq(stepReq),
    .stepUp(stepUp), .quad(quad), .phaseA(phA), .phaseB(phB));
  task end_of_test;
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    t = 0;
    do begin @(posedge clock); t++; end while (pready !== 1'b1 && t < 20);
    r = prdata;
    lastErr = pslverr;
    psel <= 0;
    penable <= 0;
    if (t >= 20) miscompares++;
  endtask
  // Steps are spaced eight cycles so no edge falls between counter ticks.
  // The gate drawn with a step is the one the counter sees when that step lands.
  task steps(input int cnt, input logic up);
    opened = 0;
    repeat (cnt) begin
      gateBit = 1'($urandom);
      opened += gateBit;
      stepUp <= up; stepReq <= 1; gateInput <= gateBit;
      @(posedge clock);
      stepReq <= 0;
      repeat (7) @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask
  function logic [31:0] ctl(input int code, input int mode);
    return 32'h8000 | (code << 4) | mode;
  endfunction
  function logic [31:0] inr(input logic [31:0] v, input int lo, input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction
  // Main sequence; counts are taken as ranges since the APB writes that start and stop each run add cycles.
  initial begin
    void'($urandom(32'h9e68b5c4));
    repeat (10) @(posedge clock);
    resetn <= 1;
    for (k = 0; k < 3; k++) begin apb(0, 4 * k, 0); check(r, 0); end
    apb(0, 12'h020, 0); check({31'h0, lastErr}, 1); check(r, 0);
    p0 = $urandom & 32'hffff; apb(1, 12'h004, p0); apb(0, 12'h004, 0); check(r, p0);
    apb(1, 12'h014, 32'h0720 | ($urandom & 3));
    for (k = 0; k < 8; k++) begin
      apb(1, 12'h008, 0); apb(1, 12'h004, 0);
      p0 = positionCount;
      apb(1, 12'h000, ctl(k, 3));
      repeat (256) @(posedge clock);
      apb(1, 12'h000, 0); apb(0, 12'h008, 0);
      check(inr(r, 256 >> k, (264 >> k) + 1), 1);
      check(inr(positionCount - p0, 256 >> k, (264 >> k) + 1), 1);
    end
    apb(1, 12'h004, 32'hffff); apb(1, 12'h008, 32'hffff);
    apb(1, 12'h000, ctl(0, 3)); apb(1, 12'h000, 0); apb(0, 12'h004, 0); check(r, 0);
    apb(1, 12'h014, 0); apb(1, 12'h000, ctl(0, 0));
    p0 = positionCount; n = $urandom_range(20, 5);
    steps(n, 1); check(positionCount, p0 + n); check({31'h0, countDirUp}, 1);
    steps(3, 0); check(positionCount, p0 + n - 3); check({31'h0, countDirUp}, 0);
    // With gating on, only steps taken while the gate pin is high may count.
    apb(1, 12'h000, ctl(0, 0) | 32'h4); p0 = positionCount;
    steps(8, 1); check(positionCount, p0 + opened);
    quad <= 0;
    for (k = 1; k < 3; k++) begin
      apb(1, 12'h000, ctl(0, k)); p0 = positionCount;
      steps(8, 0); check(positionCount, k == 1 ? p0 - 4 : p0 + 4);
    end
    quad <= 1;
    apb(1, 12'h000, ctl(0, 0)); steps(3, 1); p0 = positionCount;
    apb(1, 12'h014, 32'h20 | {~phB, ~phA}); steps(0, 1); check(positionCount, p0);
    apb(1, 12'h014, 32'h38 | {~phB, ~phA}); steps(0, 1); check(positionCount, 0);
    end_of_test;
  end
  // Watchdog well beyond the roughly three thousand cycles the sequence takes.
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    end_of_test;
  end
endmodule // testbench
bind qcm_counter qcm_counter_chk #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) u_chk (.clock(clock),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .positionCount(positionCount),
  .countDirUp(countDirUp));
